// *** core/asp_cfg.svh ***
// Offsets, field positions, reset values and timing counts of the angle serial slave
`ifndef ASP_CFG_SVH
`define ASP_CFG_SVH
// ======================================================================
// Frame layout
`define ASP_FRAME_BITS     16
`define ASP_CNT_W          5
`define ASP_OP_READ        3'h2
`define ASP_OP_WRITE       3'h4
// ======================================================================
// Configuration register indices and fields
`define ASP_NUM_REGS       32
`define ASP_REG_ZERO       5'h00
`define ASP_REG_FLD_LOW    5'h06
`define ASP_REG_FLD_HIGH   5'h07
`define ASP_REG_DIR        5'h09
`define ASP_DIR_BIT        7
`define ASP_REG_FLAGS      5'h1b
`define ASP_FLAG_HIGH_BIT  6
`define ASP_FLAG_LOW_BIT   7
`define ASP_RST_REG        8'h00
`define ASP_RST_FLD_LOW    8'h20
`define ASP_RST_FLD_HIGH   8'he0
// ======================================================================
// Timing
`define ASP_CLK_PERIOD_NS  100
`define ASP_SCLK_MAX_MHZ   25
`define ASP_ANGLE_GAP_NS   150
`define ASP_ANGLE_GAP_CYC  ((`ASP_ANGLE_GAP_NS + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)
`define ASP_REG_GAP_NS     750
`define ASP_REG_GAP_CYC    ((`ASP_REG_GAP_NS + `ASP_CLK_PERIOD_NS - 1) / `ASP_CLK_PERIOD_NS)
`define ASP_NVM_WAIT_MS    20
`define ASP_NVM_WAIT_CYC   ((`ASP_NVM_WAIT_MS * 1000000) / `ASP_CLK_PERIOD_NS)
`define ASP_NVM_CNT_W      18
`define ASP_SAMPLE_KHZ     1000
// ======================================================================
// Post-filter: tau = 0.38 / cutoff, gains as shifts for a 1 us step
`define ASP_TAU_X100       38
`define ASP_CUTOFF_HZ      90
`define ASP_FILT_FRAC      24
`define ASP_FILT_PROP_SH   11
`define ASP_FILT_VEL_SH    24
`define ASP_FIFO_DEPTH     8
`endif

// *** core/asp_pkg.sv ***
// Types shared by the angle serial slave
`default_nettype none
package asp_pkg;
  // ======================================================================
  // What the next frame shifts out
  typedef enum logic [1:0] {
    ASP_RESP_ANGLE = 2'b00,
    ASP_RESP_READ  = 2'b01,
    ASP_RESP_WRITE = 2'b10
  } asp_resp_t;

  // Serial pins sampled together
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic mosi;
  } asp_pins_t;

  // Received command frame
  typedef struct packed {
    logic [2:0] op;
    logic [4:0] addr;
    logic [7:0] data;
  } asp_cmd_t;
endpackage
`default_nettype wire

// *** core/asp_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module asp_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 8
) (
  input  wire logic             sys_clk,   // Clock
  input  wire logic             reset,     // Sync reset, high
  input  wire logic             in_valid,  // Write request
  input  wire logic [WIDTH-1:0] in_data,   // Write data
  output logic                  in_ready,  // Not full
  output logic                  out_valid, // Not empty
  input  wire logic             out_ready, // Reader takes word
  output logic [WIDTH-1:0]      out_data   // Head word
);
  // ======================================================================
  // Storage; DEPTH must be a power of two so the pointers wrap freely
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0]    wr_q;
  logic [AW-1:0]    rd_q;
  logic [AW:0]      cnt_q;
  logic [AW:0]      cnt_d;
  logic             room_q;
  logic             empty_q;
  logic             push;
  logic             pop;

  assign push      = in_valid & room_q;
  assign pop       = out_ready & ~empty_q;
  assign in_ready  = room_q;
  assign out_valid = ~empty_q;
  assign out_data  = mem_q[rd_q];
  assign cnt_d     = cnt_q + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};

  // Full and empty kept in flops so the ready pins stay glitch free
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      wr_q    <= '0;
      rd_q    <= '0;
      cnt_q   <= '0;
      room_q  <= 1'b1;
      empty_q <= 1'b1;
    end else begin
      if (push) begin
        wr_q <= wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= rd_q + 1'b1;
      end
      cnt_q   <= cnt_d;
      room_q  <= (cnt_d != (AW+1)'(DEPTH));
      empty_q <= (cnt_d == '0);
    end
  end

  // Data array needs no reset
  always_ff @(posedge sys_clk) begin
    if (push) begin
      mem_q[wr_q] <= in_data;
    end
  end
endmodule
`default_nettype wire

// *** core/asp_spi_slave.sv ***
// Angle sensor serial slave: SPI frames, configuration store, post-filter, field flags
//
// Function
// - Frames in clock mode 0 or 3 accepted; falling edges before the first rising edge are ignored.
// - Outgoing bit changes on falling edge, incoming bit sampled on rising edge.
// - This port does angle reads and programming; no other port programs.
// - Front-end supplies a new angle sample every microsecond.
// - Post-filter response (1+2 tau s)/(1+tau s)^2, tau = 0.38 / cutoff.
// - Post-filter tracks a constant-rate angle ramp without lag.
// - Default settings: angle grows with clockwise field rotation.
// - Counting direction and zero reference are programmable.
// - Low-field output high while field strength is below low threshold.
// - High-field output high while field strength is above high threshold.
// - Select pulled up, data-in and clock pulled down internally.
// - Data-out pull-down enabled whenever data-out is not driven.
// - Angle buffer frozen at select fall, released at select rise.
// - Angle sent MSB first, zero bits pad to sixteen.
// - Read: command 010, address, zeros; next frame returns register byte.
// - Write: command 100, address, byte; next frame returns stored byte.
`timescale 1ns/1ps
`default_nettype none
`include "asp_cfg.svh"
module asp_spi_slave #(
  parameter int NVM_WAIT_CYC = `ASP_NVM_WAIT_CYC
) (
  input  wire logic       sys_clk,             // 10 MHz clock
  input  wire logic       reset,               // Sync reset, high
  input  wire logic       spi_cs_n,            // Select pin, low active
  input  wire logic       spi_sclk,            // Serial clock pin
  input  wire logic       spi_mosi,            // Serial data in pin
  output logic            spi_miso_o,          // Serial data out level
  output logic            spi_miso_oe,         // Data out drive enable
  output logic            miso_pulldown_en,    // Data out keeper
  output logic            cs_pullup_en,        // Select pull-up
  output logic            mosi_pulldown_en,    // Data in pull-down
  output logic            sclk_pulldown_en,    // Clock pull-down
  input  wire logic [7:0] fe_angle,            // Front-end sample
  input  wire logic       fe_valid,            // Sample strobe
  output logic            fe_ready,            // FIFO has room
  input  wire logic [7:0] field_strength,      // Measured field
  output logic            field_low_flag_out,  // Field below low threshold
  output logic            field_high_flag_out, // Field above high threshold
  output logic [7:0]      angle_out,           // Filtered, mapped angle
  output logic            nvm_busy             // Write in progress
);
  // ======================================================================
  // Declarations
  asp_pkg::asp_pins_t        pins_meta_q;
  asp_pkg::asp_pins_t        pins_sync_q;
  asp_pkg::asp_pins_t        pins_prev_q;
  asp_pkg::asp_resp_t        resp_q;
  asp_pkg::asp_cmd_t         cmd;
  logic [15:0]               rx_q;
  logic [15:0]               tx_q;
  logic [`ASP_CNT_W-1:0]     cnt_q;
  logic                      seen_rise_q;
  logic [4:0]                resp_addr_q;
  logic [7:0]                cfg_q [`ASP_NUM_REGS];
  logic [`ASP_NVM_CNT_W-1:0] nvm_cnt_q;
  logic [4:0]                pend_addr_q;
  logic [7:0]                pend_data_q;
  logic                      nvm_busy_q;
  logic                      oe_q;
  logic                      pd_q;
  logic                      pulls_q;
  logic                      flag_low_q;
  logic                      flag_high_q;
  logic [7:0]                angle_buf_q;
  logic                      cs_fall;
  logic                      cs_rise;
  logic                      sclk_rise;
  logic                      sclk_fall;
  logic                      selected;
  logic                      frame_ok;
  logic                      wr_take;
  logic [7:0]                reg_rd;
  logic [7:0]                zero_ref;
  logic                      dir_ccw;
  logic                      fifo_valid;
  logic [7:0]                fifo_data;
  logic signed [31:0]        err_q;
  logic signed [31:0]        vel_q;
  logic [31:0]               pos_q;
  logic                      filt_busy_q;
  logic                      filt_upd_q;

  // ======================================================================
  // Pin synchroniser: meta flop feeds only the sync flop
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      pins_meta_q <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
      pins_sync_q <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
      pins_prev_q <= '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0};
    end else begin
      pins_meta_q <= '{cs_n: spi_cs_n, sclk: spi_sclk, mosi: spi_mosi};
      pins_sync_q <= pins_meta_q;
      pins_prev_q <= pins_sync_q;
    end
  end

  // Edge detection on synchronised pins; sys_clk must oversample sclk
  assign selected  = ~pins_sync_q.cs_n;
  assign cs_fall   = pins_prev_q.cs_n & ~pins_sync_q.cs_n;
  assign cs_rise   = ~pins_prev_q.cs_n & pins_sync_q.cs_n;
  assign sclk_rise = ~pins_prev_q.sclk & pins_sync_q.sclk;
  assign sclk_fall = pins_prev_q.sclk & ~pins_sync_q.sclk;

  // ======================================================================
  // Configuration view
  assign zero_ref = cfg_q[`ASP_REG_ZERO];
  assign dir_ccw  = cfg_q[`ASP_REG_DIR][`ASP_DIR_BIT];
  assign cmd      = asp_pkg::asp_cmd_t'(rx_q);
  assign frame_ok = cs_rise && (cnt_q == `ASP_CNT_W'(`ASP_FRAME_BITS));
  assign wr_take  = frame_ok && (cmd.op == `ASP_OP_WRITE) && (nvm_cnt_q == '0)
                    && (cmd.addr != `ASP_REG_FLAGS);

  // Flag register is live state, the rest is the stored table
  always_comb begin
    reg_rd = cfg_q[resp_addr_q];
    if (resp_addr_q == `ASP_REG_FLAGS) begin
      reg_rd                    = 8'h00;
      reg_rd[`ASP_FLAG_LOW_BIT] = flag_low_q;
      reg_rd[`ASP_FLAG_HIGH_BIT] = flag_high_q;
    end
  end

  // ======================================================================
  // Shift engine; shifting waits for a first rising edge, so mode 3's
  // leading falling edge does not skip the MSB
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      rx_q        <= 16'h0000;
      tx_q        <= 16'h0000;
      cnt_q       <= '0;
      seen_rise_q <= 1'b0;
    end else if (cs_fall) begin
      rx_q        <= 16'h0000;
      cnt_q       <= '0;
      seen_rise_q <= 1'b0;
      case (resp_q)
        asp_pkg::ASP_RESP_READ:  tx_q <= {reg_rd, 8'h00};
        asp_pkg::ASP_RESP_WRITE: tx_q <= {reg_rd, 8'h00};
        default:                 tx_q <= {angle_buf_q, 8'h00};
      endcase
    end else if (selected) begin
      if (sclk_rise) begin
        rx_q        <= {rx_q[14:0], pins_sync_q.mosi};
        seen_rise_q <= 1'b1;
        if (cnt_q != '1) begin
          cnt_q <= cnt_q + 1'b1;
        end
      end else if (sclk_fall && seen_rise_q) begin
        tx_q <= {tx_q[14:0], 1'b0};
      end
    end
  end

  // ======================================================================
  // Command decode at frame end; only this port can program
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      resp_q      <= asp_pkg::ASP_RESP_ANGLE;
      resp_addr_q <= 5'h00;
    end else if (cs_rise) begin
      resp_q      <= asp_pkg::ASP_RESP_ANGLE;
      resp_addr_q <= cmd.addr;
      if (frame_ok) begin
        case (cmd.op)
          `ASP_OP_READ:  resp_q <= asp_pkg::ASP_RESP_READ;
          `ASP_OP_WRITE: resp_q <= asp_pkg::ASP_RESP_WRITE;
          default:       resp_q <= asp_pkg::ASP_RESP_ANGLE;
        endcase
      end
    end
  end

  // ======================================================================
  // Non-volatile store: a write lands only after the wait, so an early
  // readback sees the old byte; writes during the wait are dropped
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      nvm_cnt_q   <= '0;
      nvm_busy_q  <= 1'b0;
      pend_addr_q <= 5'h00;
      pend_data_q <= 8'h00;
    end else if (wr_take) begin
      nvm_cnt_q   <= `ASP_NVM_CNT_W'(NVM_WAIT_CYC);
      nvm_busy_q  <= 1'b1;
      pend_addr_q <= cmd.addr;
      pend_data_q <= cmd.data;
    end else if (nvm_cnt_q != '0) begin
      nvm_cnt_q  <= nvm_cnt_q - 1'b1;
      nvm_busy_q <= (nvm_cnt_q != `ASP_NVM_CNT_W'(1)); // Falls with the commit
    end
  end

  // Register table; zero defaults give clockwise-positive angles
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      for (int i = 0; i < `ASP_NUM_REGS; i++) begin
        cfg_q[i] <= `ASP_RST_REG;
      end
      cfg_q[`ASP_REG_FLD_LOW]  <= `ASP_RST_FLD_LOW;
      cfg_q[`ASP_REG_FLD_HIGH] <= `ASP_RST_FLD_HIGH;
    end else if (nvm_cnt_q == `ASP_NVM_CNT_W'(1)) begin
      cfg_q[pend_addr_q] <= pend_data_q;
    end
  end

  // ======================================================================
  // Sample FIFO between front-end and filter
  asp_fifo #(
    .WIDTH (8),
    .DEPTH (`ASP_FIFO_DEPTH)
  ) u_fifo (
    .sys_clk   (sys_clk),
    .reset     (reset),
    .in_valid  (fe_valid),
    .in_data   (fe_angle),
    .in_ready  (fe_ready),
    .out_valid (fifo_valid),
    .out_ready (~filt_busy_q),
    .out_data  (fifo_data)
  );

  // Second-order tracking loop: gain 1/tau^2 on the integrator and 2/tau
  // on the direct path gives (1+2 tau s)/(1+tau s)^2, type 2, so a ramp
  // is followed with no lag; gains rounded to shifts at one sample per us
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      err_q       <= 32'sh0;
      vel_q       <= 32'sh0;
      pos_q       <= 32'h0;
      filt_busy_q <= 1'b0;
      filt_upd_q  <= 1'b0;
    end else if (filt_busy_q) begin
      vel_q       <= vel_q + (err_q >>> `ASP_FILT_VEL_SH);
      pos_q       <= pos_q + 32'(vel_q) + 32'(err_q >>> `ASP_FILT_PROP_SH);
      filt_busy_q <= 1'b0;
      filt_upd_q  <= 1'b1;
    end else begin
      filt_upd_q <= 1'b0;
      if (fifo_valid) begin
        err_q       <= signed'({fifo_data, 24'h000000} - pos_q); // Wraps mod 360
        filt_busy_q <= 1'b1;
      end
    end
  end

  // Output buffer refresh, held while selected
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      angle_buf_q <= 8'h00;
    end else if (filt_upd_q && !selected) begin
      if (dir_ccw) begin
        angle_buf_q <= zero_ref - pos_q[31:24];
      end else begin
        angle_buf_q <= pos_q[31:24] - zero_ref;
      end
    end
  end

  // ======================================================================
  // Field comparators, no hysteresis in this model
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      flag_low_q  <= 1'b0;
      flag_high_q <= 1'b0;
    end else begin
      flag_low_q  <= field_strength < cfg_q[`ASP_REG_FLD_LOW];
      flag_high_q <= field_strength > cfg_q[`ASP_REG_FLD_HIGH];
    end
  end

  // Pad control: drive only while selected, keeper otherwise
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      oe_q    <= 1'b0;
      pd_q    <= 1'b1;
      pulls_q <= 1'b1;
    end else begin
      oe_q    <= selected;
      pd_q    <= ~selected;
      pulls_q <= 1'b1;
    end
  end

  assign spi_miso_o          = tx_q[15];
  assign spi_miso_oe         = oe_q;
  assign miso_pulldown_en    = pd_q;
  assign cs_pullup_en        = pulls_q;
  assign mosi_pulldown_en    = pulls_q;
  assign sclk_pulldown_en    = pulls_q;
  assign field_low_flag_out  = flag_low_q;
  assign field_high_flag_out = flag_high_q;
  assign angle_out           = angle_buf_q;
  assign nvm_busy            = nvm_busy_q;

  // ======================================================================
  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);

  sequence read_end_s;
    frame_ok && (cmd.op == `ASP_OP_READ);
  endsequence
  sequence write_end_s;
    wr_take;
  endsequence

  first_fall_hold_a: assert property (
    selected && sclk_fall && !seen_rise_q && !cs_fall |=> tx_q == $past(tx_q))
    else $error("tx shifted before first rising edge");
  tx_shift_a: assert property (
    selected && sclk_fall && seen_rise_q && !cs_fall |=> tx_q == {$past(tx_q[14:0]), 1'b0})
    else $error("tx did not shift on falling edge");
  rx_sample_a: assert property (
    selected && sclk_rise && !cs_fall |=> rx_q[0] == $past(pins_sync_q.mosi))
    else $error("rx did not sample on rising edge");
  angle_load_a: assert property (
    cs_fall && resp_q == asp_pkg::ASP_RESP_ANGLE |=> tx_q == {$past(angle_buf_q), 8'h00})
    else $error("angle word not loaded at select fall");
  buf_freeze_a: assert property (
    selected && $past(selected) |-> $stable(angle_buf_q))
    else $error("angle buffer changed while selected");
  read_decode_a: assert property (
    read_end_s |=> resp_q == asp_pkg::ASP_RESP_READ && resp_addr_q == $past(cmd.addr))
    else $error("read command not decoded");
  write_wait_a: assert property (
    write_end_s |=> nvm_busy [*8])
    else $error("write finished too early");
  write_commit_a: assert property (
    $fell(nvm_busy) |-> cfg_q[pend_addr_q] == pend_data_q)
    else $error("pending write not stored");
  miso_release_a: assert property (
    cs_rise |=> !spi_miso_oe ##0 miso_pulldown_en)
    else $error("data out still driven after deselect");
  miso_keeper_a: assert property (
    spi_miso_oe != miso_pulldown_en)
    else $error("keeper and driver both on or both off");
  pad_pulls_a: assert property (
    cs_pullup_en && mosi_pulldown_en && sclk_pulldown_en)
    else $error("input pulls not enabled");
  field_low_a: assert property (
    ##1 field_low_flag_out == $past(field_strength < cfg_q[`ASP_REG_FLD_LOW]))
    else $error("low-field flag wrong");
  field_high_a: assert property (
    ##1 field_high_flag_out == $past(field_strength > cfg_q[`ASP_REG_FLD_HIGH]))
    else $error("high-field flag wrong");
endmodule
`default_nettype wire

// *** dv/asp_master.sv ***
// Behavioural SPI master that stands in front of the angle serial slave
`timescale 1ns/1ps
`default_nettype none
module asp_master (
  input  wire logic sys_clk,  // Pacing clock
  output logic      spi_cs_n, // Select, low active
  output logic      spi_sclk, // Serial clock
  output logic      spi_mosi, // Serial data to slave
  input  wire logic miso_pin  // Resolved data-out wire
);
  // ======================================================================
  // Timing: 400 ns per clock level, well under the maximum rate
  localparam int HALF = 4;
  localparam int GAP  = 8; // 800 ns idle covers both frame gaps

  // Idle bus at time zero
  initial begin
    spi_cs_n = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
  end

  task automatic pause(input int n);
    repeat (n) @(negedge sys_clk);
  endtask

  // One frame: change on falling edge, sample on rising edge
  task automatic xfer(input logic mode3, input logic [15:0] tx, input int nbits,
                      output logic [15:0] rx);
    rx = 16'h0000;
    spi_sclk = mode3;
    pause(GAP);
    spi_cs_n = 1'b0;
    spi_mosi = tx[15];
    pause(2 * HALF);
    for (int i = 0; i < nbits; i++) begin
      if (mode3) begin
        spi_sclk = 1'b0;
        spi_mosi = tx[15-i];
        pause(HALF);
      end
      spi_sclk = 1'b1;
      rx[15-i] = miso_pin;
      pause(HALF);
      if (!mode3) begin
        spi_sclk = 1'b0;
        spi_mosi = (i < 15) ? tx[14-i] : 1'b0;
        pause(HALF);
      end
    end
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0; // Released line sits at its pull-down level
    pause(GAP); // Clock rests at this mode's idle level until the next frame
  endtask
endmodule
`default_nettype wire

// *** dv/asp_spi_slave_tb_top.sv ***
// Self-checking bench for the angle serial slave
`timescale 1ns/1ps
`default_nettype none
module asp_spi_slave_tb_top;
  // ======================================================================
  // Signals
  logic        sys_clk, reset, cs_n, sclk, mosi, miso_o, miso_oe, miso_pd;
  logic        cs_pu, mosi_pd, sclk_pd, fe_valid, fe_ready, flag_lo, flag_hi, nvm_busy;
  logic [7:0]  fe_angle, field, angle_out;
  logic [15:0] rx;
  int          n_fail, samples_checked;
  logic [7:0]  fv [4] = '{8'h1f, 8'h20, 8'he0, 8'he1};
  logic [1:0]  fx [4] = '{2'b10, 2'b00, 2'b00, 2'b01};
  // Undriven data-out falls to its pull-down, else shows a floating high
  wire logic   miso_pin = miso_oe ? miso_o : (miso_pd ? 1'b0 : 1'b1);

  asp_spi_slave #(.NVM_WAIT_CYC(20)) dut (
    .sys_clk(sys_clk), .reset(reset), .spi_cs_n(cs_n), .spi_sclk(sclk),
    .spi_mosi(mosi), .spi_miso_o(miso_o), .spi_miso_oe(miso_oe),
    .miso_pulldown_en(miso_pd), .cs_pullup_en(cs_pu), .mosi_pulldown_en(mosi_pd),
    .sclk_pulldown_en(sclk_pd), .fe_angle(fe_angle), .fe_valid(fe_valid),
    .fe_ready(fe_ready), .field_strength(field), .field_low_flag_out(flag_lo),
    .field_high_flag_out(flag_hi), .angle_out(angle_out), .nvm_busy(nvm_busy)
  );

  asp_master mst (
    .sys_clk(sys_clk), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_mosi(mosi),
    .miso_pin(miso_pin)
  );

  // 10 MHz clock
  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // ======================================================================
  // Tasks
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic results;
    $display("checked=%0d failed=%0d", samples_checked, n_fail);
    if (n_fail == 0 && samples_checked > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask

  // Bounded wait: pick 0 watches nvm_busy, 1 watches fe_ready
  task automatic wait_sig(input logic pick, input logic lvl);
    int k;
    for (k = 0; k < 200; k++) begin
      if ((pick ? fe_ready : nvm_busy) === lvl)
        break;
      @(negedge sys_clk);
    end
    if (k == 200) begin
      n_fail++;
      results();
    end
  endtask

  task automatic frame(input logic m3, input logic [15:0] tx);
    mst.xfer(m3, tx, 16, rx);
  endtask

  task automatic rd_reg(input logic [4:0] a, input logic [7:0] exp);
    frame(1'b0, {3'b010, a, 8'h00});
    frame(1'b1, 16'h0000);
    chk(rx, {exp, 8'h00});
  endtask

  // Write then readback; wt waits out the commit first, else the early readback sees the old byte
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d, input logic wt,
                        input logic [7:0] ack);
    frame(1'b1, {3'b100, a, d});
    chk(nvm_busy, 1'b1);
    if (wt)
      wait_sig(1'b0, 1'b0);
    frame(1'b0, 16'h0000);
    chk(rx, {ack, 8'h00});
  endtask

  // ======================================================================
  // Main sequence
  initial begin
    reset = 1'b1;
    fe_valid = 1'b0;
    fe_angle = 8'h00;
    field = 8'h80;
    n_fail = 0;
    samples_checked = 0;
    repeat (3) @(negedge sys_clk);
    reset = 1'b0;
    // Pads released with pulls on, flags clear
    chk({miso_oe, miso_pd, cs_pu, mosi_pd, sclk_pd, flag_lo, flag_hi, nvm_busy}, 16'h0078);
    chk(angle_out, 16'h0000);
    // Constant zero angle stream overruns the filter's pop rate
    fe_valid = 1'b1;
    wait_sig(1'b1, 1'b0);
    chk(fe_ready, 1'b0);
    // Thresholds at their reset values, strict comparisons
    for (int i = 0; i < 4; i++) begin
      field = fv[i];
      repeat (3) @(negedge sys_clk);
      chk({flag_lo, flag_hi}, fx[i]);
    end
    field = 8'h1f;
    rd_reg(5'h1b, 8'h80);
    field = 8'h80;
    rd_reg(5'h06, 8'h20);
    rd_reg(5'h07, 8'he0);
    rd_reg(5'h09, 8'h00);
    frame(1'b0, 16'h0000);
    chk(rx, 16'h0000);
    // Zero reference moves angle to 0 - 0x10
    wr_reg(5'h00, 8'h10, 1'b1, 8'h10);
    chk(angle_out, 8'hf0);
    frame(1'b1, 16'h0000);
    chk(rx, 16'hf000);
    mst.xfer(1'b0, 16'h0000, 8, rx);
    chk(rx, 16'hf000);
    chk({miso_oe, miso_pd}, 2'b01);
    // Counterclockwise counting
    wr_reg(5'h09, 8'h80, 1'b1, 8'h80);
    frame(1'b0, 16'h0000);
    chk(rx, 16'h1000);
    // Readback before commit returns the old byte, commit lands later
    wr_reg(5'h06, 8'h40, 1'b0, 8'h20);
    wait_sig(1'b0, 1'b0);
    rd_reg(5'h06, 8'h40);
    field = 8'h3f;
    repeat (3) @(negedge sys_clk);
    chk({flag_lo, flag_hi}, 2'b10);
    // Stream stops, buffer drains
    fe_valid = 1'b0;
    wait_sig(1'b1, 1'b1);
    chk(fe_ready, 1'b1);
    results();
  end
endmodule
`default_nettype wire
